// ### rtl/laie_exec.v
// Execution datapath for logic, arithmetic and watchdog-clear opcodes.
`timescale 1ns/100ps
`include "laie_consts.vh"
// How it works
// - One instruction per clock only when config_word bit 11 is zero.
// - AND file register with W, result to file register, zero flag only.
// - AND file register into W, file untouched, zero flag updated.
// - Top nibble 1110: AND literal into W, zero flag updated.
// - Complement file register in place, zero flag updated.
// - OR W into file register, result stored there, zero flag.
// - OR W with file register, result into W, zero flag.
// - Top nibble 1101: OR literal into W, zero flag.
// - XOR W into file register, result there, zero flag.
// - XOR file register into W, file kept, zero flag.
// - Top nibble 1111: XOR literal into W, zero flag.
// - Add W to file register; carry added when carry_include_bit is 0.
// - Add file register to W; carry added when carry_include_bit is 0.
// - Watchdog clear resets counter, sets timeout and power-down flags.
// - Decrement file register in place, zero flag updated.
// - Decrement without flags; skip next, two cycles, when zero.
// - Increment file register in place, zero flag updated.
// - Increment without flags; skip next, two cycles, when zero.
// - Rotate file register left through carry, in place.
// - Rotate file register right through carry, in place.
// - Subtract W from file register; borrow used when bit is 0.
// - Swap nibbles of file register in place, flags unchanged.
// - Bits marked f address the file, bits marked k are literal.
// - Carry is status bit 0, digit carry bit 1, zero bit 2.
module laie_exec #(
  parameter WDOG_W = 8,
  parameter PRE_W = 8
) (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Register port.
  input wire [3:0] regAddr,
  input wire [11:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [11:0] regRdata,
  // Watchdog ticks and execution report.
  input wire wdogTick,
  output reg skipNext,
  output reg execDone,
  output reg wdogExpired
);
  // ****************************************************************
  // State.
  // ****************************************************************
  reg [11:0] ctrl_q;
  reg [7:0] w_q;
  reg [7:0] stat_q;
  reg [WDOG_W-1:0] wdog_q;
  reg [PRE_W-1:0] pre_q;
  reg [4:0] fAddr_q;
  reg [7:0] fileMem_q [0:31];
  reg [11:0] op_q;
  reg opPend_q;
  reg [1:0] busy_q;
  integer i;
  // ****************************************************************
  // Decode.
  // ****************************************************************
  wire [6:0] opHi = op_q[11:5];
  wire [4:0] opF = op_q[4:0];
  wire [7:0] opK = op_q[7:0];
  wire [7:0] fv = fileMem_q[opF];
  wire cIn = stat_q[`LAIE_ST_C];
  wire useCarry = ~ctrl_q[`LAIE_CTRL_CARRYINC];
  wire runOk = ~ctrl_q[`LAIE_CTRL_DIV1];
  // A counter wrap on this tick clears the timeout flag, unless an opcode issues in the same cycle.
  wire wdogWrap = wdogTick &
    ~(ctrl_q[`LAIE_CTRL_PREWDOG] & (pre_q != {PRE_W{1'b1}})) &
    (wdog_q == {WDOG_W{1'b1}});

  function isZero;
    input [7:0] v;
    begin
      isZero = (v == 8'h00);
    end
  endfunction

  reg [7:0] res;
  reg [7:0] nStat;
  reg toFile;
  reg toW;
  reg skipD;
  reg wdClr;
  reg [8:0] sum;
  reg [4:0] nib;
  always @* begin
    res = 8'h00;
    nStat = stat_q;
    toFile = 1'b0;
    toW = 1'b0;
    skipD = 1'b0;
    wdClr = 1'b0;
    sum = 9'h000;
    nib = 5'h00;
    if (op_q[11:8] == `LAIE_NIB_ANDL) begin
      res = w_q & opK;
      toW = 1'b1;
      nStat[`LAIE_ST_Z] = isZero(res);
    end else if (op_q[11:8] == `LAIE_NIB_ORL) begin
      res = w_q | opK;
      toW = 1'b1;
      nStat[`LAIE_ST_Z] = isZero(res);
    end else if (op_q[11:8] == `LAIE_NIB_XORL) begin
      res = w_q ^ opK;
      toW = 1'b1;
      nStat[`LAIE_ST_Z] = isZero(res);
    end else if (op_q[11:1] == `LAIE_OP_WDCLR) begin
      wdClr = 1'b1;
      nStat[`LAIE_ST_TO] = 1'b1;
      nStat[`LAIE_ST_PD] = 1'b1;
    end else begin
      case (opHi)
        `LAIE_OP_ANDFW: begin
          res = fv & w_q;
          toFile = 1'b1;
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_ANDWF: begin
          res = fv & w_q;
          toW = 1'b1;
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_NOTF: begin
          res = fv ^ 8'hFF;
          toFile = 1'b1;
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_ORFW: begin
          res = fv | w_q;
          toFile = 1'b1;
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_ORWF: begin
          res = fv | w_q;
          toW = 1'b1;
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_XORFW: begin
          res = fv ^ w_q;
          toFile = 1'b1;
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_XORWF: begin
          res = fv ^ w_q;
          toW = 1'b1;
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_ADDFW, `LAIE_OP_ADDWF: begin
          sum = {1'b0, fv} + {1'b0, w_q} + {8'h00, useCarry & cIn};
          nib = {1'b0, fv[3:0]} + {1'b0, w_q[3:0]} +
            {4'h0, useCarry & cIn};
          res = sum[7:0];
          toFile = (opHi == `LAIE_OP_ADDFW);
          toW = (opHi == `LAIE_OP_ADDWF);
          nStat[`LAIE_ST_C] = sum[8];
          nStat[`LAIE_ST_DC] = nib[4];
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_SUBFW: begin
          // Carry set means no borrow, so the sum form adds the inverse.
          sum = {1'b0, fv} + {1'b0, ~w_q} +
            {8'h00, useCarry ? cIn : 1'b1};
          nib = {1'b0, fv[3:0]} + {1'b0, ~w_q[3:0]} +
            {4'h0, useCarry ? cIn : 1'b1};
          res = sum[7:0];
          toFile = 1'b1;
          nStat[`LAIE_ST_C] = sum[8];
          nStat[`LAIE_ST_DC] = nib[4];
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_DECF: begin
          res = fv - 8'h01;
          toFile = 1'b1;
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_MINUS_ONE_SKIP_ZERO: begin
          res = fv - 8'h01;
          toFile = 1'b1;
          skipD = isZero(res);
        end
        `LAIE_OP_INCF: begin
          res = fv + 8'h01;
          toFile = 1'b1;
          nStat[`LAIE_ST_Z] = isZero(res);
        end
        `LAIE_OP_PLUS_ONE_SKIP_ZERO: begin
          res = fv + 8'h01;
          toFile = 1'b1;
          skipD = isZero(res);
        end
        `LAIE_OP_RLF: begin
          res = {fv[6:0], cIn};
          toFile = 1'b1;
          nStat[`LAIE_ST_C] = fv[7];
        end
        `LAIE_OP_RRF: begin
          res = {cIn, fv[7:1]};
          toFile = 1'b1;
          nStat[`LAIE_ST_C] = fv[0];
        end
        `LAIE_OP_SWAPF: begin
          res = {fv[3:0], fv[7:4]};
          toFile = 1'b1;
        end
        default: begin
          res = 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // Execution and registers.
  // ****************************************************************
  wire issue = opPend_q & runOk & (busy_q == 2'h0);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `LAIE_RST_CTRL;
      w_q <= `LAIE_RST_W;
      stat_q <= `LAIE_RST_STAT;
      wdog_q <= {WDOG_W{1'b0}};
      pre_q <= {PRE_W{1'b0}};
      fAddr_q <= 5'h00;
      op_q <= 12'h000;
      opPend_q <= 1'b0;
      busy_q <= 2'h0;
      skipNext <= 1'b0;
      execDone <= 1'b0;
      wdogExpired <= 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        fileMem_q[i] <= 8'h00;
      end
    end else begin
      execDone <= 1'b0;
      skipNext <= 1'b0;
      if (busy_q != 2'h0) begin
        busy_q <= busy_q - 2'h1;
      end
      if (wdogTick) begin
        if (ctrl_q[`LAIE_CTRL_PREWDOG] && pre_q != {PRE_W{1'b1}}) begin
          pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
        end else begin
          pre_q <= {PRE_W{1'b0}};
          wdog_q <= wdog_q + {{(WDOG_W-1){1'b0}}, 1'b1};
          if (wdog_q == {WDOG_W{1'b1}}) begin
            wdogExpired <= 1'b1;
          end
        end
      end
      if (regWr) begin
        case (regAddr)
          `LAIE_OFF_CTRL: ctrl_q <= regWdata;
          `LAIE_OFF_WREG: w_q <= regWdata[7:0];
          `LAIE_OFF_STAT: stat_q <= regWdata[7:0];
          `LAIE_OFF_FADDR: fAddr_q <= regWdata[4:0];
          `LAIE_OFF_FDATA: fileMem_q[fAddr_q] <= regWdata[7:0];
          `LAIE_OFF_EXEC: begin
            op_q <= regWdata;
            opPend_q <= 1'b1;
          end
          default: begin
            op_q <= op_q;
          end
        endcase
      end
      // Expiry beats a software write to the status in the same cycle.
      if (wdogWrap) begin
        stat_q[`LAIE_ST_TO] <= 1'b0;
      end
      if (issue) begin
        // An opcode written in the issue cycle stays pending for its turn.
        if (!(regWr && regAddr == `LAIE_OFF_EXEC)) begin
          opPend_q <= 1'b0;
        end
        execDone <= 1'b1;
        stat_q <= nStat;
        if (toW) begin
          w_q <= res;
        end
        if (toFile) begin
          fileMem_q[opF] <= res;
        end
        if (wdClr) begin
          wdog_q <= {WDOG_W{1'b0}};
          wdogExpired <= 1'b0;
          if (ctrl_q[`LAIE_CTRL_PREWDOG]) begin
            pre_q <= {PRE_W{1'b0}};
          end
        end
        if (skipD) begin
          skipNext <= 1'b1;
          busy_q <= `LAIE_SKIP_CYC - 2'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Read port, one cycle latency.
  // ****************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 12'h000;
    end else if (regRd) begin
      case (regAddr)
        `LAIE_OFF_CTRL: regRdata <= ctrl_q;
        `LAIE_OFF_WREG: regRdata <= {4'h0, w_q};
        `LAIE_OFF_STAT: regRdata <= {4'h0, stat_q};
        `LAIE_OFF_WDOG: regRdata <= {{(12-WDOG_W){1'b0}}, wdog_q};
        `LAIE_OFF_PRE: regRdata <= {{(12-PRE_W){1'b0}}, pre_q};
        `LAIE_OFF_FADDR: regRdata <= {7'h00, fAddr_q};
        `LAIE_OFF_FDATA: regRdata <= {4'h0, fileMem_q[fAddr_q]};
        `LAIE_OFF_EXEC: regRdata <= op_q;
        `LAIE_OFF_INFO: regRdata <= {9'h000, opPend_q, busy_q};
        default: regRdata <= 12'h000;
      endcase
    end else begin
      regRdata <= 12'h000;
    end
  end
endmodule // laie_exec

// ### rtl/laie_consts.vh
// Constants for the logic and arithmetic execution datapath.
`ifndef LAIE_CONSTS_VH
`define LAIE_CONSTS_VH
// ****************************************************************
// Register offsets on the software port.
// ****************************************************************
`define LAIE_OFF_CTRL 4'h0
`define LAIE_OFF_WREG 4'h1
`define LAIE_OFF_STAT 4'h2
`define LAIE_OFF_WDOG 4'h3
`define LAIE_OFF_PRE 4'h4
`define LAIE_OFF_FADDR 4'h5
`define LAIE_OFF_FDATA 4'h6
`define LAIE_OFF_EXEC 4'h7
`define LAIE_OFF_INFO 4'h8
// ****************************************************************
// Field positions.
// ****************************************************************
`define LAIE_CTRL_DIV1 11
`define LAIE_CTRL_CARRYINC 0
`define LAIE_CTRL_PREWDOG 1
`define LAIE_ST_C 0
`define LAIE_ST_DC 1
`define LAIE_ST_Z 2
`define LAIE_ST_PD 3
`define LAIE_ST_TO 4
// ****************************************************************
// Reset values.
// ****************************************************************
`define LAIE_RST_CTRL 12'h000
`define LAIE_RST_STAT 8'h18
`define LAIE_RST_W 8'h00
// ****************************************************************
// Opcode patterns, upper seven bits for file forms.
// ****************************************************************
`define LAIE_OP_ANDFW 7'h0B
`define LAIE_OP_ANDWF 7'h0A
`define LAIE_OP_NOTF 7'h13
`define LAIE_OP_ORFW 7'h09
`define LAIE_OP_ORWF 7'h08
`define LAIE_OP_XORFW 7'h0D
`define LAIE_OP_XORWF 7'h0C
`define LAIE_OP_ADDFW 7'h0F
`define LAIE_OP_ADDWF 7'h0E
`define LAIE_OP_DECF 7'h07
`define LAIE_OP_MINUS_ONE_SKIP_ZERO 7'h17
`define LAIE_OP_INCF 7'h15
`define LAIE_OP_PLUS_ONE_SKIP_ZERO 7'h1F
`define LAIE_OP_RLF 7'h1B
`define LAIE_OP_RRF 7'h19
`define LAIE_OP_SUBFW 7'h05
`define LAIE_OP_SWAPF 7'h1D
`define LAIE_OP_WDCLR 11'h002
`define LAIE_NIB_ANDL 4'hE
`define LAIE_NIB_ORL 4'hD
`define LAIE_NIB_XORL 4'hF
`define LAIE_SKIP_CYC 2'h2
`endif

// ### verif/laie_exec_asserts.sv
// Port-level assertions for the execution datapath.
`timescale 1ns/100ps
module laie_exec_asserts #(
  parameter WDOG_W = 8,
  parameter PRE_W = 8
) (
  // Clock and reset.
  input wire clk,
  input wire arst_n,
  // Register port.
  input wire [3:0] regAddr,
  input wire [11:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [11:0] regRdata,
  // Watchdog and execution report.
  input wire wdogTick,
  input wire skipNext,
  input wire execDone,
  input wire wdogExpired
);
  // Shadow of the divider bit, since the checker cannot see inside.
  reg divHold_q;
  wire divHold_d = (regWr && regAddr == 4'h0) ? regWdata[11] : divHold_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) divHold_q <= 1'b0;
    else divHold_q <= divHold_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  exec_timing_a: assert property (regWr && regAddr == 4'h7 && !divHold_q
    |-> ##2 (execDone or ($past(skipNext) ##1 execDone)))
    else $error("opcode not executed on time");
  div_hold_a: assert property (divHold_q && $past(divHold_q)
    |-> !execDone) else $error("execution while divider bit set");
  skip_pulse_a: assert property (skipNext |=> !skipNext)
    else $error("skip pulse longer than one cycle");
  skip_done_a: assert property (skipNext |-> execDone)
    else $error("skip without execution");
  wdog_clear_a: assert property ($fell(wdogExpired) |-> execDone)
    else $error("watchdog expiry cleared without opcode");
  wdog_rise_a: assert property ($rose(wdogExpired) |-> $past(wdogTick))
    else $error("watchdog expired without tick");
  stat_width_a: assert property ($past(regRd && regAddr == 4'h2)
    |-> regRdata[11:8] == 4'h0) else $error("status upper bits set");
  unmapped_a: assert property ($past(regRd && regAddr > 4'h8)
    |-> regRdata == 12'h000) else $error("unmapped read not zero");
  rdata_idle_a: assert property (!$past(regRd)
    |-> regRdata == 12'h000) else $error("read data outside answer cycle");
endmodule // laie_exec_asserts
bind laie_exec laie_exec_asserts #(.WDOG_W(WDOG_W), .PRE_W(PRE_W))
  u_laie_exec_asserts (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .wdogTick(wdogTick), .skipNext(skipNext), .execDone(execDone),
  .wdogExpired(wdogExpired));

// ### verif/tb_top.sv
// Self-checking bench for the execution datapath.
`timescale 1ns/100ps
module tb_top;
  localparam [118:0] OPS = {7'h0B, 7'h0A, 7'h13, 7'h09, 7'h08, 7'h0D,
    7'h0C, 7'h0F, 7'h0E, 7'h07, 7'h17, 7'h15, 7'h1F, 7'h1B, 7'h19, 7'h05,
    7'h1D};
  localparam [11:0] LIT = {4'hE, 4'hD, 4'hF};
  // Sets of {W, file, status}; the last two hit both skip wraps.
  localparam [71:0] SETS = {24'h0FF11F, 24'hFF0118, 24'h00FF1D};
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg [3:0] regAddr = 4'h0;
  reg [11:0] regWdata = 12'h000;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  reg wdogTick = 1'b0;
  wire [11:0] regRdata;
  wire skipNext;
  wire execDone;
  wire wdogExpired;
  integer miscompares = 0;
  integer checks_done = 0;
  integer cycles = 0;
  integer i, s, c, n;
  reg [11:0] v, op;
  // Small counters keep the watchdog wrap within a short run.
  laie_exec #(.WDOG_W(2), .PRE_W(2)) u_laie_exec (.clk(clk),
    .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .wdogTick(wdogTick),
    .skipNext(skipNext), .execDone(execDone), .wdogExpired(wdogExpired));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end
  // ********
  // Bus tasks.
  // ********
  task give_verdict;
    begin
      if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [11:0] seen, input [11:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("Error %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // A gap cycle after each strobe avoids two drives of it in one step.
  task wr(input [3:0] a, input [11:0] d);
    begin
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [3:0] a, output [11:0] q);
    begin
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      q = regRdata;
      @(posedge clk);
    end
  endtask
  task tick;
    begin
      wdogTick <= 1'b1;
      @(posedge clk);
      wdogTick <= 1'b0;
      @(posedge clk);
    end
  endtask
  function [24:0] model(input [11:0] op, input [7:0] w, f, st, input ci);
    reg [8:0] s;
    reg [4:0] h;
    reg [7:0] nw, nf, ns;
    reg zf, zw, sk, c, b;
    begin
      nw = w;
      nf = f;
      ns = st;
      zf = 1'b0;
      zw = 1'b0;
      sk = 1'b0;
      c = ci ? 1'b0 : st[0];
      b = ci ? 1'b0 : ~st[0];
      s = f + w + c;
      h = f[3:0] + w[3:0] + c;
      casez (op[11:5])
        7'h0B: {zf, nf} = {1'b1, f & w};
        7'h0A: {zw, nw} = {1'b1, w & f};
        7'h13: {zf, nf} = {1'b1, ~f};
        7'h09: {zf, nf} = {1'b1, f | w};
        7'h08: {zw, nw} = {1'b1, w | f};
        7'h0D: {zf, nf} = {1'b1, f ^ w};
        7'h0C: {zw, nw} = {1'b1, w ^ f};
        7'h0F: {zf, ns[1], ns[0], nf} = {1'b1, h[4], s};
        7'h0E: {zw, ns[1], ns[0], nw} = {1'b1, h[4], s};
        7'h05: begin
          s = {1'b0, f} - w - b;
          h = {1'b0, f[3:0]} - w[3:0] - b;
          {zf, ns[1], ns[0], nf} = {1'b1, ~h[4], ~s[8], s[7:0]};
        end
        7'h07: {zf, nf} = {1'b1, f - 8'h01};
        7'h17: {sk, nf} = {f == 8'h01, f - 8'h01};
        7'h15: {zf, nf} = {1'b1, f + 8'h01};
        7'h1F: {sk, nf} = {f == 8'hFF, f + 8'h01};
        7'h1B: {ns[0], nf} = {f, st[0]};
        7'h19: {nf, ns[0]} = {st[0], f};
        7'h1D: nf = {f[3:0], f[7:4]};
        7'b1110???: {zw, nw} = {1'b1, w & op[7:0]};
        7'b1101???: {zw, nw} = {1'b1, w | op[7:0]};
        7'b1111???: {zw, nw} = {1'b1, w ^ op[7:0]};
        default: ;
      endcase
      if (zf) ns[2] = nf == 8'h00;
      if (zw) ns[2] = nw == 8'h00;
      model = {sk, nw, nf, ns};
    end
  endfunction
  // ********
  // Scenarios.
  // ********
  task run(input [11:0] op, input [23:0] d, input ci);
    reg [24:0] e;
    begin
      e = model(op, d[23:16], d[15:8], d[7:0], ci);
      wr(4'h0, {11'h000, ci});
      wr(4'h1, {4'h0, d[23:16]});
      wr(4'h2, {4'h0, d[7:0]});
      wr(4'h5, {7'h00, op[4:0]});
      wr(4'h6, {4'h0, d[15:8]});
      wr(4'h7, op);
      #1;
      chk("done", execDone, 12'h001);
      chk("skip", skipNext, {11'h000, e[24]});
      @(posedge clk);
      rd(4'h1, v);
      chk("w", v, {4'h0, e[23:16]});
      rd(4'h6, v);
      chk("file", v, {4'h0, e[15:8]});
      rd(4'h2, v);
      chk("status", v, {4'h0, e[7:0]});
    end
  endtask
  task t_reset;
    begin
      rd(4'h0, v);
      chk("ctrl", v, 12'h000);
      rd(4'h1, v);
      chk("w", v, 12'h000);
      rd(4'h2, v);
      chk("status", v, 12'h018);
      rd(4'h9, v);
      chk("unmap", v, 12'h000);
    end
  endtask
  task t_div;
    begin
      wr(4'h0, 12'h800);
      wr(4'h5, 12'h014);
      wr(4'h6, 12'h041);
      wr(4'h7, 12'h2B4);
      repeat (4) @(posedge clk);
      rd(4'h8, v);
      chk("pend", v[2], 12'h001);
      rd(4'h6, v);
      chk("held", v, 12'h041);
      wr(4'h0, 12'h000);
      repeat (2) @(posedge clk);
      rd(4'h6, v);
      chk("inc", v, 12'h042);
    end
  endtask
  task t_wdog;
    begin
      wr(4'h0, 12'h002);
      n = 0;
      while (wdogExpired !== 1'b1 && n < 64) begin
        tick;
        n = n + 1;
      end
      chk("expired", wdogExpired, 12'h001);
      rd(4'h2, v);
      chk("to_low", v[4:3], 12'h001);
      // Five more ticks leave both counters nonzero before the clear.
      repeat (5) tick;
      wr(4'h7, 12'h004);
      rd(4'h3, v);
      chk("wdog", v, 12'h000);
      rd(4'h4, v);
      chk("pre", v, 12'h000);
      rd(4'h2, v);
      chk("to_pd", v[4:3], 12'h003);
      chk("cleared", wdogExpired, 12'h000);
    end
  endtask
  // Back-to-back opcodes: the second waits out the skip cycle.
  task t_skip;
    begin
      wr(4'h5, 12'h003);
      wr(4'h6, 12'h001);
      wr(4'h5, 12'h004);
      wr(4'h6, 12'h07F);
      regAddr <= 4'h7;
      regWdata <= 12'h2E3;
      regWr <= 1'b1;
      @(posedge clk);
      regWdata <= 12'h2A4;
      @(posedge clk);
      regWr <= 1'b0;
      #1;
      chk("skipdone", execDone, 12'h001);
      chk("skipped", skipNext, 12'h001);
      @(posedge clk);
      #1;
      chk("gap", execDone, 12'h000);
      @(posedge clk);
      #1;
      chk("second", execDone, 12'h001);
      @(posedge clk);
      rd(4'h6, v);
      chk("inc_f", v, 12'h080);
      wr(4'h5, 12'h003);
      rd(4'h6, v);
      chk("dec_f", v, 12'h000);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    for (i = 0; i < 20; i = i + 1) begin
      op = (i < 17) ? {OPS[i*7 +: 7], 5'h08 + i[4:0]}
                    : {LIT[(i-17)*4 +: 4], 8'h3C};
      for (s = 0; s < 3; s = s + 1) begin
        for (c = 0; c < 2; c = c + 1) begin
          run(op, SETS[s*24 +: 24], c[0]);
        end
      end
    end
    t_skip;
    t_div;
    t_wdog;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    give_verdict;
  end
endmodule // tb_top
